// File: logic/sts_pkg.sv
// constants for the reliability threshold and status responder
package sts_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] ADR_FEAT = 8'h00;
   localparam logic [7:0] ADR_CYL_LO = 8'h04;
   localparam logic [7:0] ADR_CYL_HI = 8'h08;
   localparam logic [7:0] ADR_DRVHD = 8'h0C;
   localparam logic [7:0] ADR_CMD = 8'h10;
   localparam logic [7:0] ADR_STAT = 8'h14;
   localparam logic [7:0] ADR_DATA = 8'h18;
   localparam logic [7:0] ADR_THR = 8'h1C;
   localparam logic [7:0] ADR_VAL = 8'h20;
   localparam logic [1:0] ADR_ATTR_TOP = 2'h1;
   localparam int STAT_DRQ = 0;
   localparam int STAT_ERR = 1;
   localparam int STAT_EXC = 2;
   localparam int FLD_SPARE = 0;
   localparam int FLD_ERASE = 8;
   localparam logic [7:0] THR_RST = 8'h00;
   localparam logic [7:0] VAL_RST = 8'h64;
   // ----------------------------------------
   // command codes and keys
   // ----------------------------------------
   localparam logic [7:0] CMD_REL = 8'hB0;
   localparam logic [7:0] FEAT_THR = 8'hD1;
   localparam logic [7:0] FEAT_STAT = 8'hDA;
   localparam logic [7:0] KEY_LO = 8'h4F;
   localparam logic [7:0] KEY_HI = 8'hC2;
   localparam logic [7:0] BAD_LO = 8'hF4;
   localparam logic [7:0] BAD_HI = 8'h2C;
   localparam logic [2:0] DRVHD_ONES = 3'h7;
   // ----------------------------------------
   // attribute records and sector layout
   // ----------------------------------------
   localparam logic [7:0] ID_SPARE = 8'hC4;
   localparam logic [7:0] ID_ERASE = 8'hE5;
   localparam logic [31:0] CNT_IDS = 32'hC7E8CCCB;
   localparam logic [7:0] ATTR_VALUE = 8'h64;
   localparam logic [15:0] ATTR_FLAGS = 16'h0002;
   localparam logic [15:0] VERSION = 16'h0004;
   localparam logic [8:0] ENT_FIRST = 9'h002;
   localparam logic [8:0] ENT_LAST = 9'h169;
   localparam logic [3:0] ENT_OFS_LAST = 4'hB;
   localparam logic [8:0] SEC_LAST = 9'h1FF;
   typedef enum logic {ST_IDLE, ST_XFER} sts_state_t;
endpackage

// File: logic/sts_responder.sv
// reliability attribute counters, threshold sector and return-status logic
//
// Function
// [RULE1] total ECC attribute CBh counts correctable and uncorrectable ECC errors
// [RULE2] correctable ECC attribute CCh counts correctable ECC errors on reads
// [RULE3] read-count attribute E8h counts flash read commands executed
// [RULE4] UDMA CRC attribute C7h accumulates UDMA CRC errors
// [RULE5] these four attributes report fixed value byte 100 always
// [RULE6] these four carry flags 0002h advisory, bytes eight to eleven unused
// [RULE7] these four attributes never affect the return-status result
// [RULE8] host sets feature D1h, keys 4Fh/C2h, drive/head top bits ones
// [RULE9] threshold request returns exactly one 512-byte sector
// [RULE10] sector: version 0004h, thirty 12-byte entries, zero fill, checksum byte 511
// [RULE11] entry holds id then threshold, rest zero; spare C4h, erase E5h
// [RULE12] ECC, read-count and CRC entries carry zero threshold
// [RULE13] exceeded condition: return-status loads F4h and 2Ch into cylinder regs
// [RULE14] no exceeded condition: return-status loads 4Fh and C2h
// [RULE15] spare-block exceeded when its value is below its threshold
// [RULE16] erase-count exceeded when its value is below its threshold
// [RULE17] host selects return-status by feature DAh with the same keys
// [RULE18] checksum makes the modulo-256 sum of all 512 bytes zero
//
// The address map and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
module sts_responder #(
   parameter int CNT_W = 32
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic ecc_corr_i,
   input wire logic ecc_uncorr_i,
   input wire logic flash_read_i,
   input wire logic crc_err_i,
   output logic drq_o,
   output logic exceeded_o
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [7:0] feat_reg;
   logic [7:0] cyl_lo_reg;
   logic [7:0] cyl_hi_reg;
   logic [7:0] drvhd_reg;
   logic err_reg;
   logic [7:0] spare_thr_reg;
   logic [7:0] erase_thr_reg;
   logic [7:0] spare_val_reg;
   logic [7:0] erase_val_reg;
   sts_pkg::sts_state_t state_reg;
   logic [8:0] idx_reg;
   logic [3:0] ofs_reg;
   logic [4:0] ent_reg;
   logic [7:0] sum_reg;
   logic [CNT_W-1:0] cnt_reg [4];

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   wire acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr = acc & wb_we_i;
   wire rd = acc & ~wb_we_i;
   wire wr0 = wr & wb_sel_i[0];
   wire wr1 = wr & wb_sel_i[1];
   wire attr_hit = wb_adr_i[7:6] == sts_pkg::ADR_ATTR_TOP & ~wb_adr_i[5];
   wire [1:0] attr_idx = wb_adr_i[4:3];
   wire attr_hdr = wb_adr_i[2];
   wire in_xfer = state_reg == sts_pkg::ST_XFER;
   wire pop = rd & wb_adr_i == sts_pkg::ADR_DATA & in_xfer;
   wire issue = wr0 & wb_adr_i == sts_pkg::ADR_CMD & wb_dat_i[7:0] == sts_pkg::CMD_REL;
   wire cmd_other = wr0 & wb_adr_i == sts_pkg::ADR_CMD & wb_dat_i[7:0] != sts_pkg::CMD_REL;

   // ----------------------------------------
   // command qualification
   // ----------------------------------------
   wire keys_ok = cyl_lo_reg == sts_pkg::KEY_LO & cyl_hi_reg == sts_pkg::KEY_HI;
   wire drv_ok = drvhd_reg[7:5] == sts_pkg::DRVHD_ONES;
   wire go_thr = issue & feat_reg == sts_pkg::FEAT_THR & keys_ok & drv_ok; // [RULE8]
   wire go_stat = issue & feat_reg == sts_pkg::FEAT_STAT & keys_ok & drv_ok; // [RULE17]
   wire go_bad = (issue & ~go_thr & ~go_stat) | cmd_other;

   // only the spare-block and erase-count values take part
   wire spare_exc = spare_val_reg < spare_thr_reg; // [RULE15]
   wire erase_exc = erase_val_reg < erase_thr_reg; // [RULE16]
   wire exc = spare_exc | erase_exc; // [RULE7]

   // ----------------------------------------
   // threshold sector bytes
   // ----------------------------------------
   function automatic logic [7:0] ent_id(input logic [4:0] e);
      logic [7:0] r;
      r = 8'h00;
      case (e)
         5'h00: r = sts_pkg::ID_SPARE;
         5'h01: r = sts_pkg::ID_ERASE;
         5'h02, 5'h03, 5'h04, 5'h05: r = sts_pkg::CNT_IDS[8 * (e - 5'h02) +: 8];
         default: r = 8'h00;
      endcase
      return r;
   endfunction

   wire [7:0] ent_thr = ent_reg == 5'h00 ? spare_thr_reg :
      ent_reg == 5'h01 ? erase_thr_reg : 8'h00; // [RULE12]
   wire in_ent = idx_reg >= sts_pkg::ENT_FIRST & idx_reg <= sts_pkg::ENT_LAST;
   wire [7:0] ent_byte = ofs_reg == 4'h0 ? ent_id(ent_reg) :
      ofs_reg == 4'h1 ? ent_thr : 8'h00; // [RULE11]
   wire [7:0] sec_byte =
      idx_reg == 9'h000 ? sts_pkg::VERSION[7:0] :
      idx_reg == 9'h001 ? sts_pkg::VERSION[15:8] :
      idx_reg == sts_pkg::SEC_LAST ? 8'(8'h00 - sum_reg) :
      in_ent ? ent_byte : 8'h00; // [RULE10] [RULE18]

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   wire [31:0] attr_word = attr_hdr ?
      {sts_pkg::ATTR_VALUE, sts_pkg::ATTR_FLAGS, sts_pkg::CNT_IDS[8 * attr_idx +: 8]} : // [RULE5] [RULE6]
      32'(cnt_reg[attr_idx]);
   wire [31:0] stat_word = {29'h0, exc, err_reg, in_xfer};
   wire [31:0] rd_data =
      attr_hit ? attr_word :
      wb_adr_i == sts_pkg::ADR_FEAT ? {24'h0, feat_reg} :
      wb_adr_i == sts_pkg::ADR_CYL_LO ? {24'h0, cyl_lo_reg} :
      wb_adr_i == sts_pkg::ADR_CYL_HI ? {24'h0, cyl_hi_reg} :
      wb_adr_i == sts_pkg::ADR_DRVHD ? {24'h0, drvhd_reg} :
      wb_adr_i == sts_pkg::ADR_STAT ? stat_word :
      wb_adr_i == sts_pkg::ADR_DATA ? {24'h0, in_xfer ? sec_byte : 8'h00} :
      wb_adr_i == sts_pkg::ADR_THR ? {16'h0, erase_thr_reg, spare_thr_reg} :
      wb_adr_i == sts_pkg::ADR_VAL ? {16'h0, erase_val_reg, spare_val_reg} :
      32'h0000_0000;

   // ----------------------------------------
   // bus answer
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= acc;
         if (rd)
         begin
            wb_dat_o <= rd_data;
         end
      end
   end

   // ----------------------------------------
   // task file registers
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         feat_reg <= 8'h00;
         cyl_lo_reg <= 8'h00;
         cyl_hi_reg <= 8'h00;
         drvhd_reg <= 8'h00;
         err_reg <= 1'b0;
      end
      else
      begin
         if (wr0 & wb_adr_i == sts_pkg::ADR_FEAT)
         begin
            feat_reg <= wb_dat_i[7:0];
         end
         if (wr0 & wb_adr_i == sts_pkg::ADR_DRVHD)
         begin
            drvhd_reg <= wb_dat_i[7:0];
         end
         if (go_stat)
         begin
            cyl_lo_reg <= exc ? sts_pkg::BAD_LO : sts_pkg::KEY_LO; // [RULE13] [RULE14]
            cyl_hi_reg <= exc ? sts_pkg::BAD_HI : sts_pkg::KEY_HI; // [RULE13] [RULE14]
         end
         else
         begin
            if (wr0 & wb_adr_i == sts_pkg::ADR_CYL_LO)
            begin
               cyl_lo_reg <= wb_dat_i[7:0];
            end
            if (wr0 & wb_adr_i == sts_pkg::ADR_CYL_HI)
            begin
               cyl_hi_reg <= wb_dat_i[7:0];
            end
         end
         if (go_bad)
         begin
            err_reg <= 1'b1;
         end
         else if (go_thr | go_stat)
         begin
            err_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // thresholds and current values
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         spare_thr_reg <= sts_pkg::THR_RST;
         erase_thr_reg <= sts_pkg::THR_RST;
         spare_val_reg <= sts_pkg::VAL_RST;
         erase_val_reg <= sts_pkg::VAL_RST;
         exceeded_o <= 1'b0;
      end
      else
      begin
         if (wr0 & wb_adr_i == sts_pkg::ADR_THR)
         begin
            spare_thr_reg <= wb_dat_i[sts_pkg::FLD_SPARE +: 8];
         end
         if (wr1 & wb_adr_i == sts_pkg::ADR_THR)
         begin
            erase_thr_reg <= wb_dat_i[sts_pkg::FLD_ERASE +: 8];
         end
         if (wr0 & wb_adr_i == sts_pkg::ADR_VAL)
         begin
            spare_val_reg <= wb_dat_i[sts_pkg::FLD_SPARE +: 8];
         end
         if (wr1 & wb_adr_i == sts_pkg::ADR_VAL)
         begin
            erase_val_reg <= wb_dat_i[sts_pkg::FLD_ERASE +: 8];
         end
         exceeded_o <= exc;
      end
   end

   // ----------------------------------------
   // sector transfer
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg <= sts_pkg::ST_IDLE;
         idx_reg <= 9'h000;
         ofs_reg <= 4'h0;
         ent_reg <= 5'h00;
         sum_reg <= 8'h00;
         drq_o <= 1'b0;
      end
      else if (go_thr)
      begin
         state_reg <= sts_pkg::ST_XFER;
         idx_reg <= 9'h000;
         ofs_reg <= 4'h0;
         ent_reg <= 5'h00;
         sum_reg <= 8'h00;
         drq_o <= 1'b1;
      end
      else if (go_stat | go_bad)
      begin
         state_reg <= sts_pkg::ST_IDLE;
         drq_o <= 1'b0;
      end
      else if (pop)
      begin
         sum_reg <= 8'(sum_reg + sec_byte); // [RULE18]
         idx_reg <= 9'(idx_reg + 9'h001);
         if (in_ent)
         begin
            ofs_reg <= ofs_reg == sts_pkg::ENT_OFS_LAST ? 4'h0 : 4'(ofs_reg + 4'h1);
            ent_reg <= ofs_reg == sts_pkg::ENT_OFS_LAST ? 5'(ent_reg + 5'h01) : ent_reg;
         end
         if (idx_reg == sts_pkg::SEC_LAST)
         begin
            state_reg <= sts_pkg::ST_IDLE; // [RULE9]
            drq_o <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // attribute counters
   // ----------------------------------------
   wire [3:0] inc = {crc_err_i, flash_read_i, ecc_corr_i, ecc_corr_i | ecc_uncorr_i}; // [RULE1] [RULE2] [RULE3] [RULE4]

   generate
      for (genvar i = 0; i < 4; i++)
      begin : g_cnt
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               cnt_reg[i] <= '0;
            end
            else if (inc[i] & ~&cnt_reg[i])
            begin
               cnt_reg[i] <= cnt_reg[i] + 1'b1; // [RULE1] [RULE2] [RULE3] [RULE4]
            end
         end
      end
   endgenerate
endmodule

// File: verification/sts_responder_checker.sv
// assertion checker for the reliability responder
`timescale 1ns/1ps
module sts_responder_checker #(
   parameter int CNT_W = 32
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic ecc_corr_i,
   input wire logic ecc_uncorr_i,
   input wire logic flash_read_i,
   input wire logic crc_err_i,
   input wire logic drq_o,
   input wire logic exceeded_o
);
   // ------
   // shadow of the task-file writes
   // ------
   logic [7:0] feat_reg, lo_reg, hi_reg, dh_reg;
   logic [15:0] thr_reg, val_reg;
   logic [8:0] cnt_reg;
   wire tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire l0 = tk && wb_we_i && wb_sel_i[0];
   wire cmd_wr = tk && wb_we_i && wb_adr_i == sts_pkg::ADR_CMD;
   wire dat_rd = tk && !wb_we_i && wb_adr_i == sts_pkg::ADR_DATA && drq_o;
   wire keys = lo_reg == 8'h4F && hi_reg == 8'hC2 && dh_reg[7:5] == 3'h7;
   wire go = cmd_wr && l0 && wb_dat_i[7:0] == 8'hB0 && keys;
   wire thr_go = go && feat_reg == 8'hD1;
   wire st_go = go && feat_reg == 8'hDA;
   wire exc_now = val_reg[7:0] < thr_reg[7:0] || val_reg[15:8] < thr_reg[15:8];
   wire [15:0] nx = wb_sel_i[1] ? wb_dat_i[15:0] : {8'h00, wb_dat_i[7:0]};
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         {feat_reg, lo_reg, hi_reg, dh_reg} <= 32'h0;
         thr_reg <= 16'h0;
         val_reg <= 16'h6464;
         cnt_reg <= 9'h0;
      end
      else
      begin
         if (l0 && wb_adr_i == sts_pkg::ADR_FEAT) feat_reg <= wb_dat_i[7:0];
         if (l0 && wb_adr_i == sts_pkg::ADR_CYL_LO) lo_reg <= wb_dat_i[7:0];
         if (l0 && wb_adr_i == sts_pkg::ADR_CYL_HI) hi_reg <= wb_dat_i[7:0];
         if (l0 && wb_adr_i == sts_pkg::ADR_DRVHD) dh_reg <= wb_dat_i[7:0];
         if (l0 && wb_adr_i == sts_pkg::ADR_THR) thr_reg <= wb_sel_i[1] ? nx : {thr_reg[15:8], nx[7:0]};
         if (l0 && wb_adr_i == sts_pkg::ADR_VAL) val_reg <= wb_sel_i[1] ? nx : {val_reg[15:8], nx[7:0]};
         if (st_go) lo_reg <= exceeded_o ? 8'hF4 : 8'h4F;
         if (st_go) hi_reg <= exceeded_o ? 8'h2C : 8'hC2;
         if (cmd_wr) cnt_reg <= 9'h0;
         else if (dat_rd) cnt_reg <= cnt_reg + 9'h1;
      end
   end
   // ------
   // properties
   // ------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack; tk |=> wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("no ack after request");
   property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack1: assert property (p_ack1) else $error("ack longer than one cycle");
   property p_start; thr_go |-> ##[1:2] drq_o; endproperty
   a_start: assert property (p_start) else $error("sector not started");
   property p_hold; dat_rd && cnt_reg != 9'h1FF |=> drq_o; endproperty
   a_hold: assert property (p_hold) else $error("sector ended early");
   property p_end; dat_rd && cnt_reg == 9'h1FF |-> ##[1:2] !drq_o; endproperty
   a_end: assert property (p_end) else $error("sector longer than 512");
   property p_exc; exceeded_o == $past(exc_now); endproperty
   a_exc: assert property (p_exc) else $error("exceeded flag wrong");
   property p_bad; cmd_wr && wb_dat_i[7:0] != 8'hB0 |-> ##[1:2] !drq_o; endproperty
   a_bad: assert property (p_bad) else $error("bad command not aborted");
   property p_st; st_go |=> !drq_o; endproperty
   a_st: assert property (p_st) else $error("status left a transfer running");
   property p_rst; @(posedge clk_i) disable iff (1'b0) rst_i |=> !wb_ack_o && !drq_o && !exceeded_o; endproperty
   a_rst: assert property (p_rst) else $error("outputs active in reset");
   c_thr: cover property (thr_go);
   c_end: cover property (dat_rd && cnt_reg == 9'h1FF);
   c_st: cover property (st_go && exceeded_o);
endmodule
bind sts_responder sts_responder_checker #(.CNT_W(CNT_W)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ecc_corr_i(ecc_corr_i),
   .ecc_uncorr_i(ecc_uncorr_i), .flash_read_i(flash_read_i), .crc_err_i(crc_err_i), .drq_o(drq_o),
   .exceeded_o(exceeded_o));

// File: verification/sts_host.sv
// host model driving the task-file registers over the bus
`timescale 1ns/1ps
module sts_host (
   input wire logic clk_i,
   input wire logic ack_i,
   output logic cyc_o = 1'b0,
   output logic stb_o = 1'b0,
   output logic we_o = 1'b0,
   output logic [7:0] adr_o = 8'h00,
   output logic [3:0] sel_o = 4'h0,
   output logic [31:0] dat_o = 32'h0
);
   task automatic xfer(input logic [7:0] a, input logic [31:0] d, input logic w);
      @(posedge clk_i);
      {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'h3, w, a, 4'hF, d};
      do @(posedge clk_i); while (ack_i !== 1'b1);
      {cyc_o, stb_o, dat_o} <= {2'h0, ~d};
   endtask
   // keys and drive/head ones, then the reliability command
   task automatic cmd(input logic [7:0] f, input logic [7:0] lo);
      xfer(sts_pkg::ADR_FEAT, {24'h0, f}, 1'b1);
      xfer(sts_pkg::ADR_CYL_LO, {24'h0, lo}, 1'b1);
      xfer(sts_pkg::ADR_CYL_HI, 32'hC2, 1'b1);
      xfer(sts_pkg::ADR_DRVHD, 32'hE0, 1'b1);
      xfer(sts_pkg::ADR_CMD, 32'hB0, 1'b1);
   endtask
endmodule

// File: verification/sts_responder_tb.sv
// self-checking bench for the reliability responder
`timescale 1ns/1ps
module sts_responder_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [3:0] ev = 4'h0;
   logic [3:0] r;
   logic cyc, stb, we, ack, drq, exc;
   logic [7:0] adr, sum;
   logic [3:0] sel;
   logic [31:0] dw, dr;
   logic [15:0] thr;
   logic [31:0] q[$];
   logic [31:0] cnt[4];
   logic [7:0] sec[512];
   logic [7:0] eid[6] = '{8'hC4, 8'hE5, 8'hCB, 8'hCC, 8'hE8, 8'hC7};
   logic [31:0] vt[4] = '{32'h64641010, 32'h64100011, 32'h05640600, 32'h10101010};
   int num_errors = 0;
   int total_checks = 0;
   always #10 clk_i = ~clk_i;
   sts_host u_host (.clk_i(clk_i), .ack_i(ack), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
      .sel_o(sel), .dat_o(dw));
   sts_responder u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .ecc_corr_i(ev[0]),
      .ecc_uncorr_i(ev[1]), .flash_read_i(ev[2]), .crc_err_i(ev[3]), .drq_o(drq), .exceeded_o(exc));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e)
      begin
         num_errors++;
         $display("unexpected at %0t: saw %h wanted %h", $time, s, e);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      q.push_back(e);
      u_host.xfer(a, 32'h0, 1'b0);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk_i)
   begin
      if (ack === 1'b1 && we === 1'b0)
         chk(dr, q.size() > 0 ? q.pop_front() : ~dr);
   end
   initial
   begin
      #200000;
      num_errors++;
      $display("unexpected at %0t: watchdog ran out", $time);
      results();
   end
   initial
   begin
      void'($urandom(96239));
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(sts_pkg::ADR_THR, 32'h0);
      rd(sts_pkg::ADR_VAL, 32'h6464);
      rd(8'hFC, 32'h0);
      $display("test reset done");
      cnt = '{default: 32'h0};
      repeat (300)
      begin
         @(posedge clk_i);
         r = 4'($urandom);
         ev <= r;
         cnt[0] += 32'(r[0] | r[1]);
         cnt[1] += 32'(r[0]);
         cnt[2] += 32'(r[2]);
         cnt[3] += 32'(r[3]);
      end
      @(posedge clk_i);
      ev <= 4'h0;
      for (int i = 0; i < 4; i++)
      begin
         rd(8'(8'h40 + 8 * i), cnt[i]);
         rd(8'(8'h44 + 8 * i), {24'h640002, eid[i + 2]});
      end
      rd(sts_pkg::ADR_STAT, 32'h0);
      $display("test counters done");
      thr = 16'($urandom);
      u_host.xfer(sts_pkg::ADR_THR, {16'h0, thr}, 1'b1);
      sec = '{default: 8'h00};
      sec[0] = 8'h04;
      for (int k = 0; k < 6; k++) sec[2 + 12 * k] = eid[k];
      sec[3] = thr[7:0];
      sec[15] = thr[15:8];
      sum = 8'h00;
      for (int i = 0; i < 511; i++) sum += sec[i];
      sec[511] = 8'h00 - sum;
      u_host.cmd(sts_pkg::FEAT_THR, 8'h4F);
      chk(32'(drq), 32'h1);
      for (int i = 0; i < 512; i++)
         rd(sts_pkg::ADR_DATA, {24'h0, sec[i]});
      chk(32'(drq), 32'h0);
      rd(sts_pkg::ADR_DATA, 32'h0);
      rd(sts_pkg::ADR_STAT, {29'h0, thr[7:0] > 8'h64 || thr[15:8] > 8'h64, 2'h0});
      $display("test sector done");
      for (int k = 0; k < 4; k++)
      begin
         u_host.xfer(sts_pkg::ADR_VAL, {16'h0, vt[k][31:16]}, 1'b1);
         u_host.xfer(sts_pkg::ADR_THR, {16'h0, vt[k][15:0]}, 1'b1);
         u_host.cmd(sts_pkg::FEAT_STAT, 8'h4F);
         r[0] = vt[k][31:24] < vt[k][15:8] || vt[k][23:16] < vt[k][7:0];
         chk(32'(exc), 32'(r[0]));
         rd(sts_pkg::ADR_CYL_LO, r[0] ? 32'hF4 : 32'h4F);
         rd(sts_pkg::ADR_CYL_HI, r[0] ? 32'h2C : 32'hC2);
      end
      $display("test status done");
      u_host.cmd(sts_pkg::FEAT_THR, 8'h4E);
      rd(sts_pkg::ADR_STAT, 32'h2);
      u_host.cmd(sts_pkg::FEAT_THR, 8'h4F);
      chk(32'(drq), 32'h1);
      u_host.xfer(sts_pkg::ADR_CMD, 32'hEC, 1'b1);
      chk(32'(drq), 32'h0);
      rd(sts_pkg::ADR_DATA, 32'h0);
      rd(sts_pkg::ADR_STAT, 32'h2);
      $display("test refusal done");
      @(posedge clk_i);
      chk(32'(q.size()), 32'h0);
      results();
   end
endmodule
